// file: rtl/crc_unit_pkg.sv
// Package: constants and carriers of the table-driven CRC execution unit
`default_nettype none
package crc_unit_pkg;
	localparam logic [7:0] CRC_OPCODE = 8'h0B;
	localparam int TABLE_ENTRIES = 16;
	localparam int MEM_ADDR_W = 32;
	localparam int LEN_W = 16;
	localparam logic [31:0] REG_ZERO = 32'h0000_0000;
	localparam logic [1:0] STEP_1 = 2'h0;
	localparam logic [1:0] STEP_2 = 2'h1;
	localparam logic [1:0] STEP_4 = 2'h2;
	localparam int RESULT_RESET = 0;

	typedef struct packed {
		logic [7:0] opcode;
		logic [31:0] table_addr;
		logic [31:0] init_crc;
		logic [15:0] str_len;
		logic [31:0] str_addr;
	} crc_cmd_t;

	typedef struct packed {
		logic [31:0] result_register;
		logic [31:0] reg1;
		logic [31:0] reg2;
		logic [31:0] reg3;
		logic bad_opcode;
	} crc_result_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_TBL = 6'b000010,
		ST_BYTE = 6'b000100,
		ST_FOLD = 6'b001000,
		ST_DONE = 6'b010000,
		ST_OUT = 6'b100000
	} crc_state_t;
endpackage : crc_unit_pkg
`default_nettype wire

// file: rtl/table_driven_crc_unit.sv
// Table-driven CRC instruction execution unit
//
// How it works
// - Decode opcode 0B with four ordered operands
// - Length is unsigned 16-bit byte count
// - Polynomial comes only from 16-entry table
// - Every string byte folded before completion
// - Byte XORed into remainder low eight bits
// - Each step shifts right, zero fills top
// - Shifted-out one XORs in the polynomial
// - Eight bit positions covered per byte
// - 1, 2 or 4 bits per step
// - Full 32-bit remainder into result register
// - Zero length returns initial remainder unchanged
// - Register one past string; two, three zero
`default_nettype none
module table_driven_crc_unit #(
	parameter int STEP_BITS = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire crc_unit_pkg::crc_cmd_t cmd,
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic res_valid,
	input wire logic res_ready,
	output crc_unit_pkg::crc_result_t res
);
	import crc_unit_pkg::*;

	// ****************************************
	// Parameter checks
	// ****************************************
	// Only widths that divide a byte and fit the 16-entry table are served
	if (STEP_BITS != 1 && STEP_BITS != 2 && STEP_BITS != 4) begin : g_bad_step
		$error("STEP_BITS must be 1, 2 or 4");
	end
	if (TABLE_ENTRIES != 16) begin : g_bad_table
		$error("table must hold 16 entries for a 4-bit index");
	end

	localparam int STEPS_PER_BYTE = 8 / STEP_BITS;
	localparam logic [3:0] IDX_SCALE = 4'((STEP_BITS == 1) ? 8 : (STEP_BITS == 2) ? 4 : 1);
	localparam logic [4:0] TBL_LAST = 5'(TABLE_ENTRIES - 1);
	localparam logic [3:0] STEP_LAST = 4'(STEPS_PER_BYTE - 1);

	// ****************************************
	// Table lookup helper
	// ****************************************
	function automatic logic [3:0] table_index(input logic [31:0] rem);
		logic [3:0] low;
		low = 4'h0;
		case (STEP_BITS)
			1: low = {3'h0, rem[0]};
			2: low = {2'h0, rem[1:0]};
			default: low = rem[3:0];
		endcase
		table_index = 4'(low * IDX_SCALE);
	endfunction : table_index

	function automatic logic is_crc_op(input logic [7:0] op);
		is_crc_op = (op == CRC_OPCODE);
	endfunction : is_crc_op

	// Byte lane picked by the low address bits of the fetched word
	function automatic logic [7:0] lane_byte(input logic [31:0] data, input logic [1:0] lane);
		lane_byte = data[{lane, 3'h0} +: 8];
	endfunction : lane_byte

	crc_state_t state_q;
	logic [31:0] poly_tbl_q [TABLE_ENTRIES];
	logic [4:0] tbl_cnt_q;
	logic [31:0] table_base_q;
	logic [31:0] working_remainder_q;
	logic [31:0] next_addr_q;
	logic [LEN_W-1:0] remaining_q;
	logic [3:0] step_q;
	logic bad_q;
	logic [31:0] shifted_rem;

	// ****************************************
	// Two-entry result buffer
	// ****************************************
	crc_result_t buf_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;
	crc_result_t push_data;

	// Buffer full stalls completion so a slow receiver loses no result
	assign push = (state_q == ST_OUT) && (count_q != 2'h2);
	assign pop = res_valid && res_ready;
	assign push_data = '{
		result_register: working_remainder_q,
		reg1: next_addr_q,
		reg2: REG_ZERO,
		reg3: REG_ZERO,
		bad_opcode: bad_q
	};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push)
			buf_q[wr_ptr_q] <= push_data;
	end

	// Outputs registered; the head is re-presented from the entry after a pop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			res_valid <= 1'b0;
			res <= '0;
		end else begin
			if (count_q == 2'h0 && push) begin
				res_valid <= 1'b1;
				res <= push_data;
			end else if (pop) begin
				if (count_q == 2'h2) begin
					res_valid <= 1'b1;
					res <= buf_q[~rd_ptr_q];
				end else if (push) begin
					res_valid <= 1'b1;
					res <= push_data;
				end else begin
					res_valid <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Control sequence
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cmd_valid) begin
						if (!is_crc_op(cmd.opcode))
							state_q <= ST_DONE;
						else
							state_q <= ST_TBL;
					end
				end
				ST_TBL: begin
					// Zero length skips the string, leaving the initial remainder
					if (mem_ack && tbl_cnt_q == TBL_LAST)
						state_q <= (remaining_q == '0) ? ST_DONE : ST_BYTE;
				end
				ST_BYTE: begin
					if (mem_ack)
						state_q <= ST_FOLD;
				end
				ST_FOLD: begin
					// Next byte only after all steps of this one
					if (step_q == STEP_LAST)
						state_q <= (remaining_q == '0) ? ST_DONE : ST_BYTE;
				end
				ST_DONE: state_q <= ST_OUT;
				ST_OUT: begin
					// Waits here while both buffer entries are occupied
					if (push)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Command acceptance
	// ****************************************
	// Ready is advisory; a command is taken in idle whatever it shows
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= (state_q == ST_IDLE) && !cmd_valid;
		end
	end

	// ****************************************
	// Memory fetch: table then string bytes
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_req <= 1'b0;
			mem_addr <= '0;
		end else begin
			// One read outstanding, held until acknowledged
			mem_req <= 1'b0;
			if (state_q == ST_IDLE && cmd_valid && is_crc_op(cmd.opcode)) begin
				mem_req <= 1'b1;
				mem_addr <= cmd.table_addr;
			end else if (state_q == ST_TBL) begin
				if (mem_ack && tbl_cnt_q != TBL_LAST) begin
					mem_req <= 1'b1;
					mem_addr <= 32'(table_base_q + {tbl_cnt_q + 5'h1, 2'h0});
				end else if (mem_ack && remaining_q != '0) begin
					mem_req <= 1'b1;
					mem_addr <= next_addr_q;
				end else begin
					mem_req <= !mem_ack;
				end
			end else if (state_q == ST_BYTE) begin
				mem_req <= !mem_ack;
			end else if (state_q == ST_FOLD && step_q == STEP_LAST
				&& remaining_q != '0) begin
				mem_req <= 1'b1;
				mem_addr <= next_addr_q;
			end
		end
	end

	// ****************************************
	// Table capture
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tbl_cnt_q <= 5'h0;
			table_base_q <= '0;
		end else if (state_q == ST_IDLE) begin
			tbl_cnt_q <= 5'h0;
			table_base_q <= cmd.table_addr;
		end else if (state_q == ST_TBL && mem_ack) begin
			tbl_cnt_q <= 5'(tbl_cnt_q + 5'h1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (state_q == ST_TBL && mem_ack)
			poly_tbl_q[tbl_cnt_q[3:0]] <= mem_rdata;
	end

	// ****************************************
	// Remainder datapath
	// ****************************************
	assign shifted_rem = working_remainder_q >> STEP_BITS;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			working_remainder_q <= '0;
			next_addr_q <= '0;
			remaining_q <= '0;
			step_q <= 4'h0;
			bad_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// Loaded for a bad opcode too, so its result echoes the operands
					if (cmd_valid) begin
						working_remainder_q <= cmd.init_crc;
						next_addr_q <= cmd.str_addr;
						remaining_q <= cmd.str_len;
						bad_q <= !is_crc_op(cmd.opcode);
					end
				end
				ST_BYTE: begin
					if (mem_ack) begin
						working_remainder_q <= working_remainder_q
							^ {24'h0, lane_byte(mem_rdata, next_addr_q[1:0])};
						next_addr_q <= 32'(next_addr_q + 32'h1);
						remaining_q <= LEN_W'(remaining_q - 1'b1);
						step_q <= 4'h0;
					end
				end
				ST_FOLD: begin
					working_remainder_q <= shifted_rem
						^ poly_tbl_q[table_index(working_remainder_q)];
					step_q <= 4'(step_q + 4'h1);
				end
				default: ;
			endcase
		end
	end
endmodule : table_driven_crc_unit
`default_nettype wire

// file: dv/crc_unit_monitor.sv
// Port checker of the table-driven CRC unit
`default_nettype none
module crc_unit_monitor #(
	parameter int STEP_BITS = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire crc_unit_pkg::crc_cmd_t cmd,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic res_valid,
	input wire logic res_ready,
	input wire crc_unit_pkg::crc_result_t res
);
	import crc_unit_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	crc_cmd_t cmd_q;
	wire take = cmd_valid && cmd_ready;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) cmd_q <= '0;
		else if (take) cmd_q <= cmd;
	end
	first_fetch_a: assert property (take && cmd.opcode == CRC_OPCODE |=>
		mem_req && mem_addr == $past(cmd.table_addr)) else $error("first fetch wrong");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("request dropped");
	res_hold_a: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
		else $error("result not held");
	regs_zero_a: assert property (res_valid |->
		res.reg2 == REG_ZERO && res.reg3 == REG_ZERO) else $error("regs not zero");
	ptr_end_a: assert property ($rose(res_valid) && !res.bad_opcode |->
		res.reg1 == cmd_q.str_addr + 32'(cmd_q.str_len)) else $error("end pointer wrong");
	zero_len_a: assert property ($rose(res_valid) && cmd_q.str_len == 16'h0 |->
		res.result_register == cmd_q.init_crc) else $error("initial value lost");
	bad_op_a: assert property ($rose(res_valid) |->
		res.bad_opcode == (cmd_q.opcode != CRC_OPCODE)) else $error("opcode misjudged");
	done_bound_a: assert property (take |-> ##[1:1000] res_valid)
		else $error("no result");
endmodule : crc_unit_monitor
bind table_driven_crc_unit crc_unit_monitor #(.STEP_BITS(STEP_BITS)) crc_unit_monitor_i (
	.clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd, .mem_req, .mem_addr, .mem_ack,
	.mem_rdata, .res_valid, .res_ready, .res);
`default_nettype wire

// file: dv/crc_mem_model.sv
// Memory model serving table words and string bytes
`default_nettype none
module crc_mem_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	input wire logic [31:0] poly,
	input wire logic [7:0] salt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_q;
	wire hit = mem_req && !mem_ack && wait_q == (mem_addr[3:2] ^ salt[1:0]);
	function automatic logic [31:0] word(input logic [31:0] a);
		logic [31:0] t;
		t = 32'(a[5:2]);
		for (int i = 0; i < 4; i++) t = t[0] ? (t >> 1) ^ poly : t >> 1;
		if (a[16]) return t;
		// Whole bytes only, so a stream needs no leading zero padding
		for (int i = 0; i < 4; i++) t[8*i +: 8] = {a[7:2], 2'(i)} ^ salt;
		return t;
	endfunction : word
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
		end else begin
			mem_ack <= hit;
			wait_q <= (mem_req && !mem_ack && !hit) ? wait_q + 2'h1 : 2'h0;
			// Inverted when idle, so a stale word never reads as fresh
			mem_rdata <= hit ? word(mem_addr) : ~mem_rdata;
		end
	end
endmodule : crc_mem_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench of the table-driven CRC unit
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import crc_unit_pkg::*;
	localparam logic [31:0] POLYS [3] = '{32'h0000_A001, 32'h0000_8408, 32'hEDB8_8320};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic res_ready = 1'b1;
	// One lane per step width, all fed the same command
	logic [2:0] cmd_ready, mem_req, mem_ack, res_valid;
	logic [2:0][31:0] mem_addr, mem_rdata;
	crc_result_t [2:0] res;
	logic [31:0] poly = 32'h0;
	logic [7:0] salt = 8'h0;
	crc_cmd_t cmd = '0;
	crc_result_t exp_q [3][$];
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	for (genvar g = 0; g < 3; g++) begin : g_lane
		crc_result_t want;
		table_driven_crc_unit #(.STEP_BITS(4 >> g)) table_driven_crc_unit_i (.clk_sys,
			.rst_n, .cmd_valid, .cmd_ready(cmd_ready[g]), .cmd, .mem_req(mem_req[g]),
			.mem_addr(mem_addr[g]), .mem_ack(mem_ack[g]), .mem_rdata(mem_rdata[g]),
			.res_valid(res_valid[g]), .res_ready, .res(res[g]));
		crc_mem_model crc_mem_model_i (.clk_sys, .rst_n, .mem_req(mem_req[g]),
			.mem_addr(mem_addr[g]), .mem_ack(mem_ack[g]), .mem_rdata(mem_rdata[g]),
			.poly, .salt);
		always @(posedge clk_sys) begin
			if (res_valid[g] === 1'b1 && res_ready) begin
				want = exp_q[g].pop_front();
				tests_run++;
				if (res[g] !== want) begin
					n_fail++;
					$display("wrong value at %0t: got %h want %h", $time, res[g], want);
				end
			end
		end
	end
	always #20 clk_sys = ~clk_sys;
	always @(negedge clk_sys) res_ready <= ($urandom % 3) != 0;
	function automatic crc_result_t expect_of(input crc_cmd_t c);
		crc_result_t e;
		logic [31:0] r;
		e = '0;
		r = c.init_crc;
		e.reg1 = c.str_addr;
		e.bad_opcode = c.opcode != CRC_OPCODE;
		for (int i = 0; i < int'(c.str_len) && !e.bad_opcode; i++) begin
			r ^= {24'h0, 8'(c.str_addr[7:0] + 8'(i)) ^ salt};
			for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ poly : r >> 1;
			e.reg1++;
		end
		e.result_register = r;
		return e;
	endfunction : expect_of
	function automatic int pending();
		return exp_q[0].size() + exp_q[1].size() + exp_q[2].size();
	endfunction : pending
	task automatic run(input logic [7:0] op, input logic [31:0] init, input logic [15:0] len,
		input logic [31:0] adr);
		crc_cmd_t c;
		c = '{op, 32'h0001_0000, init, len, adr};
		for (int g = 0; g < 3; g++) exp_q[g].push_back(expect_of(c));
		@(negedge clk_sys);
		cmd = c;
		cmd_valid = 1'b1;
		tests_run++;
		if (cmd_ready !== 3'b111) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, cmd_ready, 3'b111);
		end
		@(negedge clk_sys);
		if (op != CRC_OPCODE) @(negedge clk_sys);
		cmd_valid = 1'b0;
		for (int i = 0; i < 3000 && pending() != 0; i++) @(negedge clk_sys);
		if (pending() != 0) begin
			n_fail++;
			$display("no result, opcode %h length %0d", op, len);
			report_and_stop();
		end else begin
			$display("test done, opcode %h length %0d", op, len);
		end
	endtask : run
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			$display("cycle limit reached after %0d cycles", cycles);
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'hDE54AC1E));
		salt = 8'($urandom);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		for (int p = 0; p < 3; p++) begin
			poly = POLYS[p];
			run(CRC_OPCODE, 32'h0, 16'h0, 32'h0000_0103);
			run(CRC_OPCODE, {32{p != 0}}, 16'h9, 32'h0000_0201 + 32'(p));
			run(8'h0A + 8'(2 * p), 32'h1234_5678, 16'h5, 32'h0000_0300);
		end
		repeat (12) begin
			poly = $urandom;
			run(CRC_OPCODE, $urandom, 16'($urandom % 21), $urandom % 32'hFF00);
		end
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
